// *** core/odsr_pkg.sv ***
package odsr_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ODSR_ADDR_IDLE_0_3 = 8'h05;
  localparam logic [7:0] ODSR_ADDR_IDLE_4_7 = 8'h06;
  localparam logic [7:0] ODSR_ADDR_IDLE_8_11 = 8'h07;
  localparam logic [7:0] ODSR_ADDR_ENABLE_0_7 = 8'h08;
  localparam logic [7:0] ODSR_RST_IDLE = 8'h00;
  localparam logic [7:0] ODSR_RST_ENABLE = 8'h00;
  localparam int ODSR_NUM_OUT = 12;
  localparam int ODSR_FIELD_W = 2;
  localparam int ODSR_FIRST_EN = 2;
  localparam int ODSR_LAST_EN = 7;
  // ------------------------------------------------------------
  // Rest encodings
  // ------------------------------------------------------------
  localparam logic [1:0] ODSR_REST_BOTH_LOW = 2'h0;
  localparam logic [1:0] ODSR_REST_DRIVE_LOW = 2'h1;
  localparam logic [1:0] ODSR_REST_HIZ = 2'h2;
  typedef enum logic [1:0] {
    ODSR_ACT_BOTH_LOW,
    ODSR_ACT_DRIVE_LOW,
    ODSR_ACT_HIZ,
    ODSR_ACT_RUN
  } odsr_drive_t;
endpackage

// *** core/odsr_gate.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// One output's glitch-free gate and leg decode
// ------------------------------------------------------------
module odsr_gate (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic clk_low, // Buffered clock is low, synced
  input wire logic enable, // Enable bit from register
  input wire logic [1:0] rest, // Rest field from register
  output logic leg_p, // True leg level
  output logic leg_n, // Complement leg level
  output logic leg_oe_n, // Leg drive enable, low drives
  output logic running // Driver in steering mode
);
  import odsr_pkg::*;
  logic run_ff, nxt_run;
  logic p_ff, nxt_p, n_ff, nxt_n, oe_n_ff, nxt_oe_n;

  // Gate state moves only in clock-low phase to avoid runt pulses
  always_comb begin
    nxt_run = run_ff;
    if (clk_low) begin
      nxt_run = enable;
    end
  end

  // Leg decode; rest field ignored while running
  always_comb begin
    nxt_p = 1'b0;
    nxt_n = 1'b0;
    nxt_oe_n = 1'b0;
    if (nxt_run) begin
      nxt_oe_n = 1'b0;
    end else if (rest == ODSR_REST_BOTH_LOW) begin
      nxt_n = 1'b0;
    end else if (rest == ODSR_REST_DRIVE_LOW) begin
      nxt_n = 1'b1;
    end else begin
      nxt_oe_n = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_ff <= 1'b0;
      p_ff <= 1'b0;
      n_ff <= 1'b0;
      oe_n_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      p_ff <= nxt_p;
      n_ff <= nxt_n;
      oe_n_ff <= nxt_oe_n;
    end
  end

  assign leg_p = p_ff;
  assign leg_n = n_ff;
  assign leg_oe_n = oe_n_ff;
  assign running = run_ff;
endmodule

// *** core/odsr_top.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Output rest-state and enable register bank
// ------------------------------------------------------------
module odsr_top (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic variant_12, // Twelve-output variant strap
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic reg_rd, // Read strobe, one cycle
  output logic [7:0] reg_rdata, // Read data, registered
  input wire logic buf_clk, // Buffered clock level, async
  output logic [odsr_pkg::ODSR_NUM_OUT-1:0] leg_p, // True legs
  output logic [odsr_pkg::ODSR_NUM_OUT-1:0] leg_n, // Complement legs
  output logic [odsr_pkg::ODSR_NUM_OUT-1:0] leg_oe_n, // Low drives leg
  output logic [odsr_pkg::ODSR_NUM_OUT-1:0] low_power_steering_mode // Run
);
  import odsr_pkg::*;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] idle_0_3_ff, nxt_idle_0_3;
  logic [7:0] idle_4_7_ff, nxt_idle_4_7;
  logic [7:0] idle_8_11_ff, nxt_idle_8_11;
  logic [7:0] enable_ff, nxt_enable;
  logic [7:0] rdata_ff, nxt_rdata;
  logic var12_s1_ff, var12_ff;
  logic clk_s1_ff, clk_s2_ff;
  logic [3:0] en_hi;
  logic [ODSR_NUM_OUT-1:0] en_all;
  logic [2*ODSR_NUM_OUT-1:0] rest_all;

  // Write decode; only outputs 2 to 7 enables are writable here
  always_comb begin
    nxt_idle_0_3 = idle_0_3_ff;
    nxt_idle_4_7 = idle_4_7_ff;
    nxt_idle_8_11 = idle_8_11_ff;
    nxt_enable = enable_ff;
    if (reg_wr) begin
      unique case (reg_addr)
        ODSR_ADDR_IDLE_0_3: nxt_idle_0_3 = reg_wdata;
        ODSR_ADDR_IDLE_4_7: nxt_idle_4_7 = reg_wdata;
        ODSR_ADDR_IDLE_8_11: begin
          if (var12_ff) begin
            nxt_idle_8_11 = reg_wdata;
          end
        end
        ODSR_ADDR_ENABLE_0_7: begin
          nxt_enable[ODSR_LAST_EN:ODSR_FIRST_EN] =
            reg_wdata[ODSR_LAST_EN:ODSR_FIRST_EN];
        end
        default: ;
      endcase
    end
  end

  // Read mux; absent or unmapped addresses read zero
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      unique case (reg_addr)
        ODSR_ADDR_IDLE_0_3: nxt_rdata = idle_0_3_ff;
        ODSR_ADDR_IDLE_4_7: nxt_rdata = idle_4_7_ff;
        ODSR_ADDR_IDLE_8_11: nxt_rdata = var12_ff ? idle_8_11_ff : 8'h00;
        ODSR_ADDR_ENABLE_0_7: nxt_rdata = enable_ff;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idle_0_3_ff <= ODSR_RST_IDLE;
      idle_4_7_ff <= ODSR_RST_IDLE;
      idle_8_11_ff <= ODSR_RST_IDLE;
      enable_ff <= ODSR_RST_ENABLE;
      rdata_ff <= 8'h00;
    end else begin
      idle_0_3_ff <= nxt_idle_0_3;
      idle_4_7_ff <= nxt_idle_4_7;
      idle_8_11_ff <= nxt_idle_8_11;
      enable_ff <= nxt_enable;
      rdata_ff <= nxt_rdata;
    end
  end

  // Strap is a pin; two stages so a slow edge cannot go metastable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      var12_s1_ff <= 1'b0;
      var12_ff <= 1'b0;
    end else begin
      var12_s1_ff <= variant_12;
      var12_ff <= var12_s1_ff;
    end
  end

  // Clock level is asynchronous; two-stage synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_s1_ff <= 1'b0;
      clk_s2_ff <= 1'b0;
    end else begin
      clk_s1_ff <= buf_clk;
      clk_s2_ff <= clk_s1_ff;
    end
  end

  // Enables for outputs 8 to 11 sit elsewhere; held off here
  assign en_hi = 4'h0;
  assign en_all = {en_hi, enable_ff};
  assign rest_all = {idle_8_11_ff, idle_4_7_ff, idle_0_3_ff};
  assign reg_rdata = rdata_ff;

  // One gate per output
  for (genvar i = 0; i < ODSR_NUM_OUT; i++) begin : g_out
    odsr_gate u_gate (
      .mclk(mclk),
      .rst_n(rst_n),
      .clk_low(~clk_s2_ff),
      .enable(en_all[i]),
      .rest(rest_all[ODSR_FIELD_W*i +: ODSR_FIELD_W]),
      .leg_p(leg_p[i]),
      .leg_n(leg_n[i]),
      .leg_oe_n(leg_oe_n[i]),
      .running(low_power_steering_mode[i])
    );
  end
endmodule

// *** testbench/odsr_checker.sv ***
`timescale 1ns/1ps
module odsr_checker (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset
  input wire logic variant_12, // Strap
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Data in
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [7:0] reg_rdata, // Data out
  input wire logic buf_clk, // Output clock
  input wire logic [11:0] leg_p, // True legs
  input wire logic [11:0] leg_n, // Complement legs
  input wire logic [11:0] leg_oe_n, // Leg enables
  input wire logic [11:0] low_power_steering_mode // Running
);
  wire logic [11:0] run = low_power_steering_mode;
  // All checks on the system clock, quiet in reset
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Write, one idle cycle, read of the same place
  sequence s_wr(a);
    reg_wr && reg_addr == a ##1 !reg_wr ##1 reg_rd && reg_addr == a;
  endsequence
  property p_run; (run & (leg_n | leg_oe_n)) == '0; endproperty
  a_run: assert property (p_run)
    else $error("running leg at rest");
  property p_legs; leg_p == '0 && (leg_n & leg_oe_n) == '0; endproperty
  a_legs: assert property (p_legs)
    else $error("leg decode");
  property p_rst; $rose(rst_n) |-> (run | leg_oe_n | leg_n) == '0; endproperty
  a_rst: assert property (p_rst)
    else $error("reset state");
  property p_off; {run[11:8], run[1:0]} == 6'h00; endproperty
  a_off: assert property (p_off)
    else $error("fixed output ran");
  property p_bank; reg_rd && reg_addr == 8'h07 && !variant_12 |=>
    reg_rdata == 8'h00; endproperty
  a_bank: assert property (p_bank)
    else $error("absent bank read");
  property p_rw4; s_wr(8'h06) |=> reg_rdata == $past(reg_wdata, 3); endproperty
  a_rw4: assert property (p_rw4)
    else $error("rest 4-7 readback");
  property p_rwen; s_wr(8'h08) |=> reg_rdata == ($past(reg_wdata, 3) & 8'hFC);
  endproperty
  a_rwen: assert property (p_rwen)
    else $error("enable readback");
  property p_glitch; $changed(run) |-> !$past(buf_clk, 3); endproperty
  a_glitch: assert property (p_glitch)
    else $error("gate while high");
  // Main scenarios reached
  c_run: cover property (run != '0);
  c_hiz: cover property (leg_oe_n != '0);
  c_low: cover property (leg_n != '0);
endmodule

// *** testbench/odsr_top_test.sv ***
`timescale 1ns/1ps
module odsr_top_test;
  logic mclk = 1'h0, rst_n = 1'h0, variant_12 = 1'h0, buf_clk = 1'h0;
  logic reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [11:0] leg_p, leg_n, leg_oe_n, low_power_steering_mode;
  logic [11:0] run_en = 12'h000;
  logic [7:0] mdl [4:9] = '{default: 8'h00};
  int failures = 0, total_checks = 0, seed = 32'h01a5;
  // Free-running system clock
  always #25 mclk = ~mclk;
  odsr_top u_odsr_top (
    .mclk(mclk),
    .rst_n(rst_n),
    .variant_12(variant_12),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .buf_clk(buf_clk),
    .leg_p(leg_p),
    .leg_n(leg_n),
    .leg_oe_n(leg_oe_n),
    .low_power_steering_mode(low_power_steering_mode)
  );
  // Compare and count
  task automatic check(input logic [11:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Optional write, idle cycle, then read back; 4 and 9 stay unmapped
  task automatic acc(input logic w, input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    @(posedge mclk) #5 reg_wr = 1'h0;
    if (w && !(a inside {8'h04, 8'h09}) && (a != 8'h07 || variant_12))
      mdl[a] = a == 8'h08 ? d & 8'hFC : d;
    @(posedge mclk) #5 reg_rd = 1'h1;
    @(posedge mclk) #5 reg_rd = 1'h0;
    check({4'h0, reg_rdata}, {4'h0, mdl[a]});
    @(posedge mclk) #5;
  endtask
  // Expected {p, n, oe_n, run} of one output from the rules
  function automatic logic [3:0] exp_leg(input logic en,
    input logic [1:0] r);
    return en ? 4'h1 : r == 2'h0 ? 4'h0 : r == 2'h1 ? 4'h4 : 4'h2;
  endfunction
  // Expected legs from the applied enables and the rest fields
  task automatic legs;
    logic [11:0] e [4];
    logic [1:0] r;
    for (int k = 0; k < 12; k++) begin
      r = mdl[5 + k / 4][2 * (k % 4) +: 2];
      {e[0][k], e[1][k], e[2][k], e[3][k]} = exp_leg(run_en[k], r);
    end
    check(leg_p, e[0]);
    check(leg_n, e[1]);
    check(leg_oe_n, e[2]);
    check(low_power_steering_mode, e[3]);
  endtask
  // Reset values, all-ones corners, then random traffic
  initial begin
    logic [31:0] r;
    repeat (10) @(posedge mclk);
    #5 rst_n = 1'h1;
    for (int a = 4; a < 10; a++) acc(1'h0, 8'(a), 8'h00);
    legs;
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      variant_12 = i >= 30;
      // Enables change with the output clock high, so must stay pending
      buf_clk = 1'h1;
      #150 acc(1'h1, i < 6 ? 8'(i + 4) : 8'h04 + 8'(r[2:0] % 3'h6),
        i < 6 ? 8'hFF : r[15:8]);
      legs;
      buf_clk = 1'h0;
      #200 run_en = {4'h0, mdl[8][7:2], 2'h0};
      legs;
    end
    close_out;
  end
endmodule
bind odsr_top odsr_checker u_odsr_checker (
  .mclk(mclk),
  .rst_n(rst_n),
  .variant_12(variant_12),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .buf_clk(buf_clk),
  .leg_p(leg_p),
  .leg_n(leg_n),
  .leg_oe_n(leg_oe_n),
  .low_power_steering_mode(low_power_steering_mode)
);
